// >>> rtl/ipe_pkg.sv
// Constants shared by the interrupt enable, priority and pin edge logic.
// Assumes a byte-wide register port addressed by 12-bit register offsets.
package ipe_pkg;

  // Register offsets.
  localparam logic [11:0] OFS_PEND0 = 12'hFC0;
  localparam logic [11:0] OFS_G0_EN_HIGH = 12'hFC1;
  localparam logic [11:0] OFS_G0_EN_LOW = 12'hFC2;
  localparam logic [11:0] OFS_PEND1 = 12'hFC3;
  localparam logic [11:0] OFS_G1_EN_HIGH = 12'hFC4;
  localparam logic [11:0] OFS_G1_EN_LOW = 12'hFC5;
  localparam logic [11:0] OFS_PEND2 = 12'hFC6;
  localparam logic [11:0] OFS_G2_EN_HIGH = 12'hFC7;
  localparam logic [11:0] OFS_G2_EN_LOW = 12'hFC8;
  localparam logic [11:0] OFS_EDGE_POL = 12'hFCD;
  localparam logic [11:0] OFS_PORT_CHOICE = 12'hFCE;
  localparam logic [11:0] OFS_GLOBAL_CTRL = 12'hFCF;
  localparam logic [11:0] OFS_EVT_STATUS = 12'hFD0;
  localparam logic [11:0] OFS_EVT_CLEAR = 12'hFD1;
  localparam logic [11:0] OFS_EVT_ENABLE = 12'hFD2;

  // Widths and reset values.
  localparam int REG_W = 8;
  localparam int GROUPS = 3;
  localparam int SRC_W = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Global control register: bit 7 is the global request enable.
  localparam int GLOBAL_EN_BIT = 7;

  // Group numbers, also the event status bit of each group.
  localparam logic [1:0] GRP0 = 2'h0;
  localparam logic [1:0] GRP1 = 2'h1;
  localparam logic [1:0] GRP2 = 2'h2;
  localparam int EVT_W = 3;

  // Priority level of one source, high bit from the high enable register.
  typedef logic [1:0] ipe_level_type;
  localparam ipe_level_type LVL_OFF = 2'h0;
  localparam ipe_level_type LVL_LOW = 2'h1;
  localparam ipe_level_type LVL_NOMINAL = 2'h2;
  localparam ipe_level_type LVL_HIGH = 2'h3;

  // Edge polarity and port choice encodings.
  localparam logic POL_FALLING = 1'b0;
  localparam logic POL_RISING = 1'b1;
  localparam logic CHOOSE_PORTA = 1'b0;
  localparam logic CHOOSE_PORTD = 1'b1;

endpackage : ipe_pkg

// >>> rtl/ipe_pin_edge.sv
// One shared pin interrupt: pin choice, synchroniser and edge finder.
// Assumes both pins are asynchronous to CLK_SYS; choice and polarity are same-clock.
module ipe_pin_edge
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic porta_pin,
  input wire logic portd_pin,
  input wire logic port_choice_bit,
  input wire logic edge_polarity_bit,
  output logic edge_pulse
);

  logic [1:0] sync_a;
  logic [1:0] sync_d;
  logic last_sample;
  logic chosen;

  // Both pins pass two flip-flops before anything looks at them.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a <= 2'h0;
      sync_d <= 2'h0;
    end
    else
    begin
      sync_a <= {sync_a[0], porta_pin};
      sync_d <= {sync_d[0], portd_pin};
    end
  end

  // Switching the choice may show a spurious edge once; software should
  // change the choice only while the source is disabled.
  assign chosen = (port_choice_bit == ipe_pkg::CHOOSE_PORTD) ? sync_d[1] : sync_a[1];

  // Previous sample of the chosen pin, compared below.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      last_sample <= 1'b0;
    else
      last_sample <= chosen;
  end

  // One-cycle pulse on the polarity picked for this pin.
  always_comb
  begin
    if (edge_polarity_bit == ipe_pkg::POL_RISING)
      edge_pulse = chosen && !last_sample;
    else
      edge_pulse = !chosen && last_sample;
  end

endmodule : ipe_pin_edge

// >>> rtl/ipe_irq_ctrl.sv
// Interrupt enable, priority encoding and shared pin edge selection.
// Assumes a same-clock register master with one-cycle strobes, pulse sources on
// CLK_SYS and asynchronous port pins that hold each level over a clock.
//
// The implementer's own choice: the plain strobed port.
module ipe_irq_ctrl
#(
  parameter int NUM_PINS = 8
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  input wire logic [7:0] SRC_REQ_G0,
  input wire logic [7:0] SRC_REQ_G2,
  input wire logic [NUM_PINS-1:0] PORTA_PIN,
  input wire logic [NUM_PINS-1:0] PORTD_PIN,
  input wire logic CPU_ACK,
  output logic CPU_REQ,
  output logic [1:0] CPU_LEVEL,
  output logic [4:0] CPU_SOURCE,
  output logic IRQ_OUT
);

  // The group 1 registers are one byte wide, one bit per shared pin.
  if (NUM_PINS != ipe_pkg::REG_W)
  begin : g_check
    $error("NUM_PINS must equal the register width");
  end

  // Every source index group*width+bit must fit the source output.
  if (ipe_pkg::GROUPS * ipe_pkg::REG_W > (1 << $bits(CPU_SOURCE)))
  begin : g_check_src
    $error("source index does not fit the source output");
  end

  // The event register keeps one sticky bit per request group.
  if (ipe_pkg::EVT_W != ipe_pkg::GROUPS)
  begin : g_check_evt
    $error("one event bit per group is required");
  end

  // Enable pairs and pending requests, indexed by group.
  logic [7:0] enable_high [ipe_pkg::GROUPS];
  logic [7:0] enable_low [ipe_pkg::GROUPS];
  logic [7:0] pending [ipe_pkg::GROUPS];
  logic [7:0] set_vec [ipe_pkg::GROUPS];
  logic [7:0] pin_edge_polarity;
  logic [7:0] pin_port_choice;
  logic global_enable;
  logic [ipe_pkg::EVT_W-1:0] evt_status;
  logic [ipe_pkg::EVT_W-1:0] evt_enable;
  logic [ipe_pkg::EVT_W-1:0] evt_set;
  logic [NUM_PINS-1:0] pin_edge;
  logic [1:0] wr_group;
  logic wr_pend;
  logic wr_en_high;
  logic wr_en_low;
  logic ack_take;
  logic [1:0] ack_group;
  logic [2:0] ack_bit;
  ipe_pkg::ipe_level_type next_level;
  logic [4:0] next_source;
  logic [7:0] next_rd;

  // One edge finder per shared pin; choice and polarity share bit x.
  // Each edge finder owns its synchroniser, so the pins need no shared stage.
  for (genvar x = 0; x < NUM_PINS; x++)
  begin : g_pin
    ipe_pin_edge u_edge
    (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .porta_pin(PORTA_PIN[x]),
      .portd_pin(PORTD_PIN[x]),
      .port_choice_bit(pin_port_choice[x]),
      .edge_polarity_bit(pin_edge_polarity[x]),
      .edge_pulse(pin_edge[x])
    );
  end

  // Source requests per group in documented bit order.
  always_comb
  begin
    set_vec[ipe_pkg::GRP0] = SRC_REQ_G0;
    set_vec[ipe_pkg::GRP1] = pin_edge;
    set_vec[ipe_pkg::GRP2] = SRC_REQ_G2;
  end

  // Write decode for the grouped registers.
  // Only the group index and three strobes come out of it; the single-register
  // offsets are decoded beside the flops that they feed.
  always_comb
  begin
    wr_group = ipe_pkg::GRP0;
    wr_pend = 1'b0;
    wr_en_high = 1'b0;
    wr_en_low = 1'b0;
    case (ADDR)
      ipe_pkg::OFS_PEND0:
        wr_pend = WR_STB;
      ipe_pkg::OFS_G0_EN_HIGH:
        wr_en_high = WR_STB;
      ipe_pkg::OFS_G0_EN_LOW:
        wr_en_low = WR_STB;
      ipe_pkg::OFS_PEND1:
      begin
        wr_group = ipe_pkg::GRP1;
        wr_pend = WR_STB;
      end
      ipe_pkg::OFS_G1_EN_HIGH:
      begin
        wr_group = ipe_pkg::GRP1;
        wr_en_high = WR_STB;
      end
      ipe_pkg::OFS_G1_EN_LOW:
      begin
        wr_group = ipe_pkg::GRP1;
        wr_en_low = WR_STB;
      end
      ipe_pkg::OFS_PEND2:
      begin
        wr_group = ipe_pkg::GRP2;
        wr_pend = WR_STB;
      end
      ipe_pkg::OFS_G2_EN_HIGH:
      begin
        wr_group = ipe_pkg::GRP2;
        wr_en_high = WR_STB;
      end
      ipe_pkg::OFS_G2_EN_LOW:
      begin
        wr_group = ipe_pkg::GRP2;
        wr_en_low = WR_STB;
      end
      default:
        wr_group = ipe_pkg::GRP0;
    endcase
  end

  // Enable pairs; the high and low bit of one source sit in two registers.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int g = 0; g < ipe_pkg::GROUPS; g++)
      begin
        enable_high[g] <= ipe_pkg::RESET_BYTE;
        enable_low[g] <= ipe_pkg::RESET_BYTE;
      end
    end
    else
    begin
      if (wr_en_high)
        enable_high[wr_group] <= WR_DATA;
      if (wr_en_low)
        enable_low[wr_group] <= WR_DATA;
    end
  end

  // Polarity and port choice, both one bit per shared pin.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pin_edge_polarity <= ipe_pkg::RESET_BYTE;
      pin_port_choice <= ipe_pkg::RESET_BYTE;
    end
    else if (WR_STB)
    begin
      if (ADDR == ipe_pkg::OFS_EDGE_POL)
        pin_edge_polarity <= WR_DATA;
      if (ADDR == ipe_pkg::OFS_PORT_CHOICE)
        pin_port_choice <= WR_DATA;
    end
  end

  // The acknowledged source is the one currently offered to the core.
  assign ack_take = CPU_ACK && CPU_REQ;
  assign ack_group = CPU_SOURCE[4:3];
  assign ack_bit = CPU_SOURCE[2:0];

  // Global enable: set by software, dropped by an acknowledge so that the
  // handler runs without being interrupted until software enables again.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      global_enable <= 1'b0;
    else if (WR_STB && ADDR == ipe_pkg::OFS_GLOBAL_CTRL)
      global_enable <= WR_DATA[ipe_pkg::GLOBAL_EN_BIT];
    else if (ack_take)
      global_enable <= 1'b0;
  end

  // Pending bits: a write stores the byte, an acknowledge clears the served
  // bit, and a new request in the same cycle always wins over either.
  // Writing zero to a bit is how software drops a request that it has
  // polled instead of taking it through the core.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int g = 0; g < ipe_pkg::GROUPS; g++)
        pending[g] <= ipe_pkg::RESET_BYTE;
    end
    else
    begin
      for (int g = 0; g < ipe_pkg::GROUPS; g++)
      begin
        if (wr_pend && wr_group == 2'(g))
          pending[g] <= WR_DATA | set_vec[g];
        else if (ack_take && ack_group == 2'(g))
          pending[g] <= (pending[g] & ~(8'h01 << ack_bit)) | set_vec[g];
        else
          pending[g] <= pending[g] | set_vec[g];
      end
    end
  end

  // Priority search: highest level wins, ties go to the lower source number.
  // Disabled sources never beat the starting level, so they are never offered.
  // The search is a plain loop over all sources; at this clock rate the depth
  // of the comparator chain leaves ample slack.
  always_comb
  begin
    next_level = ipe_pkg::LVL_OFF;
    next_source = 5'h00;
    for (int g = 0; g < ipe_pkg::GROUPS; g++)
    begin
      for (int b = 0; b < ipe_pkg::REG_W; b++)
      begin
        if (pending[g][b] && {enable_high[g][b], enable_low[g][b]} > next_level)
        begin
          next_level = {enable_high[g][b], enable_low[g][b]};
          next_source = 5'(g * ipe_pkg::REG_W + b);
        end
      end
    end
  end

  // Registered request to the core, gated by the global enable.
  // The offer trails the pending bits by one cycle, so level and source may
  // still name the served request in the cycle after an acknowledge; the
  // request itself is already low then, and that is what the core looks at.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CPU_REQ <= 1'b0;
      CPU_LEVEL <= ipe_pkg::LVL_OFF;
      CPU_SOURCE <= 5'h00;
    end
    else
    begin
      CPU_REQ <= global_enable && !ack_take && (next_level != ipe_pkg::LVL_OFF);
      CPU_LEVEL <= next_level;
      CPU_SOURCE <= next_source;
    end
  end

  // One event per group: any new request arriving there.
  always_comb
  begin
    for (int g = 0; g < ipe_pkg::EVT_W; g++)
      evt_set[g] = |set_vec[g];
  end

  // Sticky events; a clear in the same cycle as a new event loses.
  // The enable only masks the output; status keeps collecting while masked.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      evt_status <= 3'h0;
      evt_enable <= 3'h0;
    end
    else
    begin
      if (WR_STB && ADDR == ipe_pkg::OFS_EVT_CLEAR)
        evt_status <= (evt_status & ~WR_DATA[ipe_pkg::EVT_W-1:0]) | evt_set;
      else
        evt_status <= evt_status | evt_set;
      if (WR_STB && ADDR == ipe_pkg::OFS_EVT_ENABLE)
        evt_enable <= WR_DATA[ipe_pkg::EVT_W-1:0];
    end
  end

  // Level interrupt, one cycle behind the status so it comes from a flop.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= |(evt_status & evt_enable);
  end

  // Read multiplexer; unmapped and write-only offsets read as zero.
  // The clear register reads as zero, since it holds no state of its own.
  always_comb
  begin
    case (ADDR)
      ipe_pkg::OFS_PEND0:
        next_rd = pending[ipe_pkg::GRP0];
      ipe_pkg::OFS_G0_EN_HIGH:
        next_rd = enable_high[ipe_pkg::GRP0];
      ipe_pkg::OFS_G0_EN_LOW:
        next_rd = enable_low[ipe_pkg::GRP0];
      ipe_pkg::OFS_PEND1:
        next_rd = pending[ipe_pkg::GRP1];
      ipe_pkg::OFS_G1_EN_HIGH:
        next_rd = enable_high[ipe_pkg::GRP1];
      ipe_pkg::OFS_G1_EN_LOW:
        next_rd = enable_low[ipe_pkg::GRP1];
      ipe_pkg::OFS_PEND2:
        next_rd = pending[ipe_pkg::GRP2];
      ipe_pkg::OFS_G2_EN_HIGH:
        next_rd = enable_high[ipe_pkg::GRP2];
      ipe_pkg::OFS_G2_EN_LOW:
        next_rd = enable_low[ipe_pkg::GRP2];
      ipe_pkg::OFS_EDGE_POL:
        next_rd = pin_edge_polarity;
      ipe_pkg::OFS_PORT_CHOICE:
        next_rd = pin_port_choice;
      ipe_pkg::OFS_GLOBAL_CTRL:
        next_rd = {global_enable, 7'h00};
      ipe_pkg::OFS_EVT_STATUS:
        next_rd = {5'h00, evt_status};
      ipe_pkg::OFS_EVT_ENABLE:
        next_rd = {5'h00, evt_enable};
      default:
        next_rd = ipe_pkg::READ_NONE;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      RD_DATA <= ipe_pkg::READ_NONE;
    else if (RD_STB)
      RD_DATA <= next_rd;
    else
      RD_DATA <= ipe_pkg::READ_NONE;
  end

endmodule : ipe_irq_ctrl

// >>> dv/ipe_irq_ctrl_props.sv
// Port-level checker for the interrupt enable, priority and pin edge block.
// Assumes one-cycle register strobes and a core that acknowledges only offered requests.
module ipe_irq_ctrl_props
#(
  parameter int NUM_PINS = 8
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic [7:0] SRC_REQ_G0,
  input wire logic [7:0] SRC_REQ_G2,
  input wire logic [NUM_PINS-1:0] PORTA_PIN,
  input wire logic [NUM_PINS-1:0] PORTD_PIN,
  input wire logic CPU_ACK,
  input wire logic CPU_REQ,
  input wire logic [1:0] CPU_LEVEL,
  input wire logic [4:0] CPU_SOURCE,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  logic [7:0] g0h, g0l, g0h_d, g0l_d;
  logic gen;

  // Shadow of group 0 enables and global enable; delayed copies match the output stage.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      {g0h, g0l, g0h_d, g0l_d} <= 32'h0000_0000;
      gen <= 1'b0;
    end
    else
    begin
      if (WR_STB && ADDR == ipe_pkg::OFS_G0_EN_HIGH)
        g0h <= WR_DATA;
      if (WR_STB && ADDR == ipe_pkg::OFS_G0_EN_LOW)
        g0l <= WR_DATA;
      if (WR_STB && ADDR == ipe_pkg::OFS_GLOBAL_CTRL)
        gen <= WR_DATA[7];
      else if (CPU_ACK && CPU_REQ)
        gen <= 1'b0;
      g0h_d <= g0h;
      g0l_d <= g0l;
    end
  end

  a_read_idle: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
    else $error("read data outside a read");
  a_ack_drops_req: assert property (CPU_ACK && CPU_REQ |=> !CPU_REQ)
    else $error("request stands after acknowledge");
  a_ack_stays_off: assert property ((CPU_ACK && CPU_REQ) ##1 (!WR_STB) [*2] |=> !CPU_REQ)
    else $error("request back without enable");
  a_gen_gates: assert property (!gen |=> !CPU_REQ)
    else $error("request while globally disabled");
  a_level_match: assert property (CPU_REQ && CPU_SOURCE < 5'h08 |->
    CPU_LEVEL == {g0h_d[CPU_SOURCE[2:0]], g0l_d[CPU_SOURCE[2:0]]} && CPU_LEVEL != 2'h0)
    else $error("group 0 level wrong");
  a_top_level: assert property (SRC_REQ_G0[7] && g0h[7] && g0l[7] && gen && !WR_STB &&
    !CPU_ACK ##1 (!CPU_ACK && !WR_STB) [*2] |-> CPU_REQ && CPU_LEVEL == ipe_pkg::LVL_HIGH)
    else $error("level 3 request not offered");
  a_src_range: assert property (CPU_REQ |-> CPU_SOURCE <= 5'h17 && CPU_LEVEL != 2'h0)
    else $error("offered source invalid");
  a_irq_masked: assert property (WR_STB && ADDR == ipe_pkg::OFS_EVT_ENABLE &&
    WR_DATA == 8'h00 ##1 !WR_STB |=> !IRQ_OUT)
    else $error("interrupt with all events masked");
  c_ack: cover property (CPU_ACK && CPU_REQ);
  c_high: cover property (CPU_REQ && CPU_LEVEL == ipe_pkg::LVL_HIGH);
  c_irq: cover property (IRQ_OUT);
endmodule : ipe_irq_ctrl_props

bind ipe_irq_ctrl ipe_irq_ctrl_props #(.NUM_PINS(NUM_PINS)) u_props (.CLK_SYS, .RESET_N, .ADDR,
  .WR_DATA, .WR_STB, .RD_STB, .RD_DATA, .SRC_REQ_G0, .SRC_REQ_G2, .PORTA_PIN, .PORTD_PIN,
  .CPU_ACK, .CPU_REQ, .CPU_LEVEL, .CPU_SOURCE, .IRQ_OUT);

// >>> dv/ipe_core_model.sv
// Behavioural processor core that takes offered requests and acknowledges them.
// Assumes the controller clears the served request on the acknowledge edge.
module ipe_core_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cpu_req,
  input wire logic serve,
  input wire logic [3:0] delay,
  input wire logic [4:0] cpu_source,
  output logic cpu_ack,
  output logic [4:0] taken,
  output int n_taken
);
  logic [3:0] cnt;

  // Waits a chosen number of cycles, then acknowledges for one cycle; a slow core
  // shows that an offered request stands until it is taken.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_ack <= 1'b0;
      taken <= 5'h00;
      n_taken <= 0;
      cnt <= 4'h0;
    end
    else if (cpu_ack)
    begin
      cpu_ack <= 1'b0;
      cnt <= 4'h0;
    end
    else if (serve && cpu_req && cnt >= delay)
    begin
      cpu_ack <= 1'b1;
      taken <= cpu_source;
      n_taken <= n_taken + 1;
    end
    else if (serve && cpu_req)
      cnt <= cnt + 4'h1;
  end
endmodule : ipe_core_model

// >>> dv/tb_irq_priority_enable_edge_select.sv
// Self-checking bench: registers, source pulses, pin edges, core acks and the event interrupt.
// Assumes the core model beside the design and the checker bound to it.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_irq_priority_enable_edge_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0, RESET_N = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0, serve = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [7:0] WR_DATA = 8'h00, SRC_REQ_G0 = 8'h00, SRC_REQ_G2 = 8'h00;
  logic [7:0] PORTA_PIN = 8'h00, PORTD_PIN = 8'h00, RD_DATA, pol, chs, evt = 8'h00;
  logic [3:0] delay = 4'h0;
  logic CPU_ACK, CPU_REQ, IRQ_OUT, gen = 1'b0;
  logic [1:0] CPU_LEVEL;
  logic [4:0] CPU_SOURCE, taken;
  logic [7:0] eh[3], el[3], pd[3] = '{8'h00, 8'h00, 8'h00};
  int n_taken, fails = 0, comparisons = 0;

  ipe_irq_ctrl #(.NUM_PINS(8)) u_dut (.CLK_SYS, .RESET_N, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
    .RD_DATA, .SRC_REQ_G0, .SRC_REQ_G2, .PORTA_PIN, .PORTD_PIN, .CPU_ACK, .CPU_REQ, .CPU_LEVEL,
    .CPU_SOURCE, .IRQ_OUT);
  ipe_core_model u_core (.clk(CLK_SYS), .reset_n(RESET_N), .cpu_req(CPU_REQ), .serve, .delay,
    .cpu_source(CPU_SOURCE), .cpu_ack(CPU_ACK), .taken, .n_taken);

  // Free-running system clock, 100 ns period.
  initial
  begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  // Bus cycles wait an edge first, so no strobe is assigned twice in one time step.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    @(negedge CLK_SYS);
    `CHK(RD_DATA, e)
  endtask : rchk

  task automatic pin(input int x, input logic d, input logic lv);
    @(posedge CLK_SYS);
    if (d)
      PORTD_PIN[x] <= lv;
    else
      PORTA_PIN[x] <= lv;
    repeat (4) @(posedge CLK_SYS);
  endtask : pin

  task automatic pulse(input logic [7:0] r0, input logic [7:0] r2);
    @(posedge CLK_SYS);
    SRC_REQ_G0 <= r0;
    SRC_REQ_G2 <= r2;
    @(posedge CLK_SYS);
    SRC_REQ_G0 <= 8'h00;
    SRC_REQ_G2 <= 8'h00;
    pd[0] |= r0;
    pd[2] |= r2;
    evt |= {5'h00, r2 != 0, 1'b0, r0 != 0};
  endtask : pulse

  function automatic int lvl(int s);
    return {eh[s / 8][s % 8], el[s / 8][s % 8]};
  endfunction : lvl

  // Best pending source by level, lowest index first among equals.
  task automatic expect_cpu(output int bs);
    int bl;
    bl = 0;
    bs = 0;
    for (int s = 0; s < 24; s++)
      if (pd[s / 8][s % 8] && lvl(s) > bl)
        {bl, bs} = {lvl(s), s};
    `CHK(CPU_REQ, gen && bl > 0)
    if (bl > 0)
    begin
      `CHK(CPU_LEVEL, 2'(bl))
      `CHK(CPU_SOURCE, 5'(bs))
    end
  endtask : expect_cpu

  task automatic serve_one(input int bs);
    int n0;
    n0 = n_taken;
    @(posedge CLK_SYS);
    delay <= 4'($urandom_range(5));
    serve <= 1'b1;
    for (int k = 0; k < 30 && n_taken == n0; k++)
      @(negedge CLK_SYS);
    // The ack lands on the next edge; one edge more lets the offer follow the cleared bit.
    @(posedge CLK_SYS);
    serve <= 1'b0;
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK(taken, 5'(bs))
    pd[bs / 8][bs % 8] = 1'b0;
    gen = 1'b0;
    expect_cpu(bs);
    rchk(ipe_pkg::OFS_GLOBAL_CTRL, 8'h00);
  endtask : serve_one

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Watchdog at about twenty-five times the expected run length.
  initial
  begin
    #2000000;
    fails++;
    stop_test();
  end

  // Main sequence: reset values, priority rounds, pin edges, event interrupt.
  initial
  begin
    int bs;
    void'($urandom(32'hFA91));
    repeat (4) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    for (int a = 'hFC0; a <= 'hFD2; a++)
      rchk(12'(a), 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      for (int g = 0; g < 3; g++)
      begin
        eh[g] = (i == 0) ? 8'hFF : 8'($urandom);
        el[g] = (i == 0) ? 8'hFF : 8'($urandom);
        pd[g] = 8'h00;
        wr(12'hFC1 + 12'(3 * g), eh[g]);
        wr(12'hFC2 + 12'(3 * g), el[g]);
        wr(12'hFC0 + 12'(3 * g), 8'h00);
        rchk(12'hFC1 + 12'(3 * g), eh[g]);
        rchk(12'hFC2 + 12'(3 * g), el[g]);
      end
      wr(ipe_pkg::OFS_GLOBAL_CTRL, 8'hFF);
      gen = 1'b1;
      rchk(ipe_pkg::OFS_GLOBAL_CTRL, 8'h80);
      pulse((i == 0) ? 8'h80 : 8'($urandom), 8'($urandom));
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      expect_cpu(bs);
      if (CPU_REQ === 1'b1)
        serve_one(bs);
    end
    {pol, chs, eh[1], el[1], pd[1]} = {16'($urandom), 24'hFF_0000};
    wr(ipe_pkg::OFS_EDGE_POL, pol);
    wr(ipe_pkg::OFS_PORT_CHOICE, chs);
    wr(ipe_pkg::OFS_G1_EN_HIGH, 8'hFF);
    wr(ipe_pkg::OFS_G1_EN_LOW, 8'h00);
    PORTA_PIN <= ~pol;
    PORTD_PIN <= ~pol;
    repeat (8) @(posedge CLK_SYS);
    wr(ipe_pkg::OFS_PEND1, 8'h00);
    for (int x = 0; x < 8; x++)
    begin
      pin(x, !chs[x], pol[x]);
      pin(x, !chs[x], !pol[x]);
      pin(x, chs[x], pol[x]);
      pd[1][x] = 1'b1;
      pin(x, chs[x], !pol[x]);
      rchk(ipe_pkg::OFS_PEND1, pd[1]);
    end
    evt[1] = 1'b1;
    expect_cpu(bs);
    rchk(ipe_pkg::OFS_EVT_STATUS, evt);
    wr(ipe_pkg::OFS_EVT_ENABLE, 8'h07);
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK(IRQ_OUT, 1'b1)
    wr(ipe_pkg::OFS_EVT_CLEAR, 8'h07);
    rchk(ipe_pkg::OFS_EVT_STATUS, 8'h00);
    `CHK(IRQ_OUT, 1'b0)
    wr(ipe_pkg::OFS_EVT_ENABLE, 8'h00);
    pulse(8'h01, 8'h00);
    rchk(ipe_pkg::OFS_EVT_STATUS, 8'h01);
    `CHK(IRQ_OUT, 1'b0)
    wr(ipe_pkg::OFS_EVT_ENABLE, 8'h01);
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK(IRQ_OUT, 1'b1)
    rchk(ipe_pkg::OFS_EVT_CLEAR, 8'h00);
    rchk(12'hFFF, 8'h00);
    stop_test();
  end
endmodule : tb_irq_priority_enable_edge_select
